// *** rtl/lpc_pkg.sv ***
// Purpose: Constants and types for the low-power clock stop control block
// Assumes: One core clock at 125 MHz, synchronous active-high reset
// Notes: Phase pair is generated from a divided core tick
package lpc_pkg;
   localparam int LPC_CLK_MHZ = 125;
   localparam logic [3:0] LPC_SLOW_DIV = 4'hF;      // Divide by 16 (count 0..15)
   localparam logic [3:0] LPC_FULL_DIV = 4'h0;      // Divide by 1
   localparam int LPC_NUM_INT = 4;
   localparam logic [1:0] LPC_INT_MIN_LOW = 2'h2;   // Cycles low before wake is seen
   localparam logic [0:0] LPC_WAKE_DELAY = 1'h1;    // Cycles between wake and clock restart
   localparam logic LPC_GIE_SET = 1'b1;
   typedef enum logic [2:0] {
      LPC_RUN = 3'b001,
      LPC_STOP = 3'b010,
      LPC_WAKE = 3'b100
   } lpc_state_t;
endpackage

// *** rtl/lpc_int_if.sv ***
// Purpose: Carries synchronised interrupt wake requests between modules
// Assumes: Single clock domain
// Notes: Producer is the wake filter, consumer is the control core
`timescale 1ns/1ps
`default_nettype none
interface lpc_int_if;
   logic [3:0] low_seen;
   logic arm;
   modport src (output low_seen, input arm);
   modport dst (input low_seen, output arm);
endinterface
`default_nettype wire

// *** rtl/lpc_int_filter.sv ***
// Purpose: Synchronise active-low interrupt pins and qualify a held low level
// Assumes: Pins are asynchronous to i_clk
// Notes: Filter counters run only while armed, so stale lows before stop are not seen
`timescale 1ns/1ps
`default_nettype none
module lpc_int_filter
   import lpc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_int_n,
   lpc_int_if.src bus
);
   logic [3:0] sync_a;
   logic [3:0] sync_b;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sync_a <= 4'hF;
         sync_b <= 4'hF;
      end else begin
         sync_a <= i_int_n;
         sync_b <= sync_a;
      end
   end

   for (genvar g = 0; g < LPC_NUM_INT; g++) begin : g_int
      logic [1:0] cnt;
      always_ff @(posedge i_clk) begin
         if (i_sys_rst || !bus.arm || sync_b[g]) begin
            cnt <= 2'h0;
         end else if (cnt != LPC_INT_MIN_LOW) begin
            cnt <= cnt + 2'h1;
         end
      end
      assign bus.low_seen[g] = (cnt == LPC_INT_MIN_LOW);
   end
endmodule // lpc_int_filter
`default_nettype wire

// *** rtl/lpc_clock_ctrl.sv ***
// Purpose: Low-power clock control: divide-by-16 slow mode and clock-stop idle
// Assumes: Decode strobes are one-cycle pulses from the pipeline on i_clk
// Notes: Phase outputs are a tick-driven two-phase pair, not a real clock tree
// Functional notes
// - The reduced-speed instruction divides both phase outputs by 16 from its read phase.
// - The full-speed instruction restores the undivided phase rate in its read cycle.
// - Phases may restart in either phase after slow or stop operation.
// - The clock-stop idle instruction acts as idle but halts the clock in its execute phase.
// - While stopped, phase one is high and phase three is low.
// - While stopped, all outputs hold the levels of the stop instruction's execute phase; here all hold except the phase pair, which is parked one edge later.
// - In emulation mode the clock-stop idle acts as plain idle and clocks keep running.
// - Only the four external interrupt pins wake the stopped core.
// - With no enabled interrupt, only a reset leaves the stopped state.
// - A waking interrupt adds one cycle before the clocks restart.
// - The clock-stop idle sets the global interrupt enable before the clock halts.
`timescale 1ns/1ps
`default_nettype none
module lpc_clock_ctrl
   import lpc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reduced_speed_instr,
   input wire logic i_full_speed_instr,
   input wire logic i_clock_stop_idle_instr,
   input wire logic i_idle_instr,
   input wire logic i_emulation,
   input wire logic [3:0] i_int_en,
   input wire logic [3:0] i_int_n,
   input wire logic i_periph_event,
   output logic o_clock_phase_one,
   output logic o_clock_phase_three,
   output logic o_global_interrupt_enable,
   output logic o_reduced_speed,
   output logic o_clock_stopped,
   output logic o_idle,
   output logic o_wake
);
   lpc_int_if ibus ();
   lpc_state_t state;
   lpc_state_t next_state;
   logic slow;
   logic [3:0] div_cnt;
   logic tick;
   logic emu_s1;
   logic emu;
   logic wake_hit;

   lpc_int_filter u_filter (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_int_n(i_int_n),
      .bus(ibus)
   );

   // Emulation is a level from the debug side, so it is synchronised before use
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         emu_s1 <= 1'b0;
         emu <= 1'b0;
      end else begin
         emu_s1 <= i_emulation;
         emu <= emu_s1;
      end
   end

   // Peripheral events are deliberately ignored as wake sources
   assign wake_hit = |(ibus.low_seen & i_int_en);
   assign ibus.arm = (state == LPC_STOP);

   // Instruction strobes count only in RUN; the stalled pipeline sends none while stopped
   always_comb begin
      next_state = state;
      unique case (state)
         LPC_RUN: if (i_clock_stop_idle_instr && !emu) next_state = LPC_STOP;
         LPC_STOP: if (wake_hit) next_state = LPC_WAKE;
         LPC_WAKE: next_state = LPC_RUN;
         default: next_state = LPC_RUN;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) state <= LPC_RUN;
      else state <= next_state;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) slow <= 1'b0;
      else if (state == LPC_RUN && i_full_speed_instr) slow <= 1'b0;
      else if (state == LPC_RUN && i_reduced_speed_instr) slow <= 1'b1;
   end

   // Divider clears outside RUN and after each tick, not on a speed change, so phase continuity is not kept
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || state != LPC_RUN) div_cnt <= 4'h0;
      else if (tick) div_cnt <= 4'h0;
      else div_cnt <= div_cnt + 4'h1;
   end
   assign tick = (state == LPC_RUN) && (div_cnt >= (slow ? LPC_SLOW_DIV : LPC_FULL_DIV));

   // Phase three copies the old phase one, so the pair never overlaps
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_clock_phase_one <= 1'b1;
         o_clock_phase_three <= 1'b0;
      end else if (state != LPC_RUN) begin
         o_clock_phase_one <= 1'b1;
         o_clock_phase_three <= 1'b0;
      end else if (tick) begin
         o_clock_phase_one <= ~o_clock_phase_one;
         o_clock_phase_three <= o_clock_phase_one;
      end
   end

   // Set ahead of the halt so the waking interrupt is taken; only reset clears it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) o_global_interrupt_enable <= 1'b0;
      else if (state == LPC_RUN && i_clock_stop_idle_instr) o_global_interrupt_enable <= LPC_GIE_SET;
   end

   // Status outputs freeze while stopped
   // Idle is a one-cycle flag, not stretched over the whole idle period
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reduced_speed <= 1'b0;
         o_idle <= 1'b0;
      end else if (state == LPC_RUN) begin
         o_reduced_speed <= slow;
         o_idle <= i_idle_instr || (i_clock_stop_idle_instr && emu);
      end
   end

   // Built from next_state so the flag rises on the stopping edge itself
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_clock_stopped <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_clock_stopped <= (next_state != LPC_RUN);
         o_wake <= (state == LPC_WAKE);
      end
   end

   // Checker helper: age of the current phase-one level, read from the pin itself
   logic prev_phase_one;
   logic [4:0] phase_age;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prev_phase_one <= 1'b1;
         phase_age <= 5'h00;
      end else begin
         prev_phase_one <= o_clock_phase_one;
         if (prev_phase_one != o_clock_phase_one) phase_age <= 5'h01;
         else if (phase_age != 5'h1F) phase_age <= phase_age + 5'h01;
      end
   end

   // Stop, wake and rate checks
   a_stop_phase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP |=> o_clock_phase_one && !o_clock_phase_three)
      else $error("phase pair not parked while stopped");
   a_emu_nostop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_RUN && emu && i_clock_stop_idle_instr |=> state == LPC_RUN)
      else $error("clock stopped in emulation");
   a_stop_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_RUN && !emu && i_clock_stop_idle_instr |=> state == LPC_STOP)
      else $error("clock stop idle did not stop");
   a_gie_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_RUN && i_clock_stop_idle_instr |=> o_global_interrupt_enable)
      else $error("interrupt enable not set");
   a_wake_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP && wake_hit |=> state == LPC_WAKE ##1 state == LPC_RUN)
      else $error("wake delay wrong");
   a_stay_halted: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP && !wake_hit |=> state == LPC_STOP)
      else $error("left stop without interrupt");
   a_periph_nowake: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP && i_periph_event && ((ibus.low_seen & i_int_en) == 4'h0)
      |=> state == LPC_STOP)
      else $error("peripheral event woke core");
   a_slow_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_RUN && slow && tick && !i_full_speed_instr && !i_clock_stop_idle_instr
      |=> (!tick || !slow) [*8])
      else $error("slow divide too fast");
   a_full_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_RUN && !slow |=> o_clock_phase_one != $past(o_clock_phase_one))
      else $error("full speed not undivided");
   a_status_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP |=> $stable(o_reduced_speed) && $stable(o_idle))
      else $error("outputs moved while stopped");
   a_slow_spacing: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $past(slow) && $past(state) == LPC_RUN && prev_phase_one != o_clock_phase_one
      |-> phase_age > {1'b0, LPC_SLOW_DIV})
      else $error("slow phase moved early");
   a_stop_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_STOP |-> o_clock_stopped)
      else $error("stopped flag low while stopped");
   a_wake_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state == LPC_WAKE |=> o_wake ##1 !o_wake)
      else $error("wake flag not a single cycle");

   // Reset checks
   a_reset_full: assert property (@(posedge i_clk)
      i_sys_rst |=> !slow && state == LPC_RUN)
      else $error("reset left slow or stopped");
   a_reset_pins: assert property (@(posedge i_clk)
      i_sys_rst |=> o_clock_phase_one && !o_clock_phase_three && !o_clock_stopped
      && !o_global_interrupt_enable && !o_wake)
      else $error("outputs not at reset levels");

   // Main scenarios
   c_slow: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(slow));
   c_full: cover property (@(posedge i_clk) disable iff (i_sys_rst) $fell(slow));
   c_stop: cover property (@(posedge i_clk) disable iff (i_sys_rst) state == LPC_STOP);
   c_wake: cover property (@(posedge i_clk) disable iff (i_sys_rst) state == LPC_WAKE);
   c_emu_idle: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      emu && i_clock_stop_idle_instr);
endmodule // lpc_clock_ctrl
`default_nettype wire

// *** verif/lpc_pin_model.sv ***
// Purpose: Model of the external interrupt pins seen by the clock control
// Assumes: Pins idle high through pull-ups
// Notes: A request holds the chosen pin low for three cycles, one above the minimum
`timescale 1ns/1ps
`default_nettype none
module lpc_pin_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [1:0] i_sel,
   output logic [3:0] o_int_n
);
   logic [1:0] left = 2'h0;
   // Counts on the rising edge so the falling-edge strobe from the bench is seen without a race
   always_ff @(posedge i_clk) begin
      if (i_go) left <= 2'h3;
      else if (left != 2'h0) left <= left - 2'h1;
   end
   always_comb begin
      o_int_n = 4'hF;
      if (left != 2'h0) o_int_n[i_sel] = 1'b0;
   end
endmodule // lpc_pin_model
`default_nettype wire

// *** verif/low_power_clock_stop_control_tb_top.sv ***
// Purpose: Self-checking bench for the low-power clock control
// Assumes: Inputs change on the falling edge
// Notes: Phase rate is judged by counting toggles of phase one
`timescale 1ns/1ps
`default_nettype none
module low_power_clock_stop_control_tb_top;
   import lpc_pkg::*;
   logic i_clk = 1'b0, rst = 1'b1, red = 1'b0, full = 1'b0, stp = 1'b0, idl = 1'b0;
   logic emu = 1'b0, periph = 1'b0, go = 1'b0, prev;
   logic [1:0] sel = 2'h0;
   logic [3:0] en = 4'h0, pins;
   logic p1, p3, global_interrupt_enable, slow, stopped, idle, wake;
   int error_cnt = 0, comparisons = 0, cyc = 0, n;
   lpc_clock_ctrl i_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_reduced_speed_instr(red),
      .i_full_speed_instr(full), .i_clock_stop_idle_instr(stp), .i_idle_instr(idl),
      .i_emulation(emu), .i_int_en(en), .i_int_n(pins), .i_periph_event(periph),
      .o_clock_phase_one(p1), .o_clock_phase_three(p3), .o_global_interrupt_enable(global_interrupt_enable),
      .o_reduced_speed(slow), .o_clock_stopped(stopped), .o_idle(idle), .o_wake(wake));
   lpc_pin_model i_pins (.i_clk(i_clk), .i_go(go), .i_sel(sel), .o_int_n(pins));
   initial forever #4 i_clk = ~i_clk;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(negedge i_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic toggles(input int k, output int t);
      t = 0;
      repeat (k) begin
         prev = p1;
         tick(1);
         if (p1 !== prev) t++;
      end
   endtask
   task final_report;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task t_speed;
      pulse(red);
      tick(2);
      chk(slow, 1'b1);
      toggles(32, n);
      chk(n, 8'h02);
      pulse(full);
      tick(2);
      chk(slow, 1'b0);
      toggles(8, n);
      chk(n, 8'h08);
      $display("test speed done");
   endtask
   task t_stop_wake;
      logic keep;
      en = 4'h1;
      pulse(stp);
      // The stopping edge still moves the pair; it is parked one edge later
      tick(1);
      chk({p1, p3, global_interrupt_enable, stopped}, 4'hB);
      keep = idle;
      pulse(periph);
      tick(20);
      chk({p1, p3, stopped, idle}, {3'h5, keep});
      pulse(go);
      n = 0;
      while (wake !== 1'b1 && n < 12) begin
         tick(1);
         n++;
      end
      chk(wake, 1'b1);
      tick(3);
      chk(stopped, 1'b0);
      toggles(4, n);
      chk(n, 8'h04);
      $display("test stop and wake done");
   endtask
   task t_emulation;
      emu = 1'b1;
      tick(4);
      pulse(stp);
      // Idle flag stands and the clock does not stop
      chk({stopped, idle}, 2'h1);
      toggles(8, n);
      chk(n, 8'h08);
      emu = 1'b0;
      tick(4);
      $display("test emulation done");
   endtask
   task t_no_enable;
      en = 4'h0;
      pulse(red);
      pulse(stp);
      pulse(go);
      tick(30);
      chk(stopped, 1'b1);
      chk(slow, 1'b1);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      chk({stopped, slow, p1, p3}, 4'h2);
      tick(1);
      toggles(8, n);
      chk(n, 8'h08);
      $display("test reset wake done");
   endtask
   // Hang guard: far above the roughly 150 cycles the tests need
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      tick(5);
      rst = 1'b0;
      chk({p1, p3, slow, stopped, global_interrupt_enable}, 5'h10);
      tick(1);
      t_speed();
      t_stop_wake();
      t_emulation();
      t_no_enable();
      final_report();
   end
endmodule // low_power_clock_stop_control_tb_top
`default_nettype wire
